//--- src/pnc_handler.sv
// device-side nop and packet command handler with wishbone task-file registers
// ******************************************************
// Functional notes
// - nop subcommand 00h flushes queue, aborts
// - other nop subcommands abort, queue untouched
// - nop ends abrt err drdy, no bsy/drq
// - nop changes only error and status
// - df set only on device fault
// - a0h starts packet protocol when supported
// - ovl requests overlap, dma selects data dma
// - sector count upper field carries queue tag
// - byte count limit per pio drq
// - zero limit with pio data aborts command
// - limit ffffh behaves as fffeh
// - packet wait: cd=1 io=0 drq=1 others clear; drdy is kept set here
// - byte count shows limit during packet wait
// - serv flags another command ready
// - data phase: cd=0 drq=1, io gives direction
// - dmrd set for dma with overlap dma
// - chunk nonzero, within limit and fffeh
// - chunks even except odd final chunk
// - success: io=1 cd=1 drdy=1 rest clear
// - no error before packet fully written
// ******************************************************
module pnc_handler
  import pnc_pkg::*;
#(
  parameter int PKT_BYTES   = 12,
  parameter bit PACKET_SUP  = 1'b1,
  parameter bit OVL_SUP     = 1'b1,
  parameter bit QUEUE_SUP   = 1'b1,
  parameter bit DMA_OVL_SUP = 1'b1
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        queue_abort_o,
  output logic                        pkt_valid_o,
  output logic      [8*PKT_BYTES-1:0] pkt_data_o,
  output logic                        pkt_ovl_o,
  output logic                        pkt_dma_o,
  output logic      [4:0]             pkt_tag_o,
  input  wire logic                   xfer_start_i,
  input  wire logic [23:0]            xfer_len_i,
  input  wire logic                   xfer_to_host_i,
  input  wire logic [15:0]            rd_data_i,
  output logic                        rd_take_o,
  output logic      [15:0]            wr_data_o,
  output logic                        wr_valid_o,
  input  wire logic                   cmd_done_i,
  input  wire logic                   cmd_err_i,
  input  wire logic [3:0]             sense_i,
  input  wire logic                   dev_fault_i,
  input  wire logic                   serv_i
);
  localparam int PKT_WORDS = PKT_BYTES / 2;
  localparam int WCNT_W    = $clog2(PKT_WORDS + 1);

  // the packet is taken one 16-bit word per data write
  if (PKT_BYTES < 2 || PKT_BYTES % 2 != 0 || PKT_BYTES > 64) begin : g_bad_pkt
    $error("PKT_BYTES must be even, 2..64");
  end

  // ******************************************************
  // chunk sizing
  // ******************************************************
  function automatic logic [15:0] chunk_size(input logic [23:0] rem, input logic [15:0] lim);
    logic [15:0] eff;
    eff = (lim == PNC_BC_ALL_ONES) ? PNC_BC_MAX : lim;
    if (rem <= {8'h00, eff}) begin
      chunk_size = rem[15:0];
    end else begin
      chunk_size = {eff[15:1], 1'b0};
    end
  endfunction

  // ******************************************************
  // wishbone slave
  // ******************************************************
  logic        ack_q;
  logic [31:0] dat_q;
  logic        wr_fire;
  logic        rd_fire;
  logic        sel_lo;

  pnc_state_t  state_q;
  pnc_status_t stat_q;
  logic [7:0]  error_q;
  logic [7:0]  feat_q;
  logic [7:0]  count_q;
  logic [7:0]  secnum_q;
  logic [15:0] bcount_q;
  logic [7:0]  devsel_q;
  logic        in_packet_q;
  logic [15:0] limit_q;
  logic [23:0] remain_q;
  logic [15:0] left_q;
  logic        to_host_q;
  logic [7:0]  status_rd;
  logic [WCNT_W-1:0] wcnt_q;
  logic [8*PKT_BYTES-1:0] pkt_q;

  assign sel_lo  = wb_sel_i[0];
  assign wr_fire = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && sel_lo;
  assign rd_fire = wb_cyc_i && wb_stb_i && ack_q && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  // df is live outside packet commands, serv is live inside them
  always_comb begin
    status_rd = {stat_q.bsy, stat_q.drdy, stat_q.df_dmrd, stat_q.serv, stat_q.drq, 2'b00, stat_q.err_chk};
    if (in_packet_q) begin
      status_rd[4] = serv_i;
    end else begin
      status_rd[5] = dev_fault_i;
    end
  end

  // unmapped offsets read as zero and still acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
      case (wb_adr_i)
        PNC_OFS_DATA:   dat_q <= {16'h0000, (state_q == PNC_PIO && to_host_q) ? rd_data_i : 16'h0000};
        PNC_OFS_FEAT:   dat_q <= {24'h000000, error_q};
        PNC_OFS_COUNT:  dat_q <= {24'h000000, count_q};
        PNC_OFS_SECNUM: dat_q <= {24'h000000, secnum_q};
        PNC_OFS_BCLO:   dat_q <= {24'h000000, bcount_q[7:0]};
        PNC_OFS_BCHI:   dat_q <= {24'h000000, bcount_q[15:8]};
        PNC_OFS_DEVSEL: dat_q <= {24'h000000, devsel_q};
        PNC_OFS_CMD:    dat_q <= {24'h000000, status_rd};
        default:        dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ******************************************************
  // command decode and protocol sequencing
  // ******************************************************
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic tf_open;
  logic [15:0] first_chunk;

  assign tf_open     = !stat_q.bsy && !stat_q.drq;
  assign cmd_wr      = wr_fire && wb_adr_i == PNC_OFS_CMD && tf_open;
  assign data_wr     = wr_fire && wb_adr_i == PNC_OFS_DATA && wb_sel_i[1];
  assign data_rd     = rd_fire && wb_adr_i == PNC_OFS_DATA;
  assign first_chunk = chunk_size(xfer_len_i, limit_q);

  // host-written task file; held while busy so nop never alters them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feat_q   <= PNC_RST_TF;
      secnum_q <= PNC_RST_TF;
      devsel_q <= PNC_RST_TF;
    end else if (wr_fire && tf_open) begin
      if (wb_adr_i == PNC_OFS_FEAT) begin
        feat_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == PNC_OFS_SECNUM) begin
        secnum_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == PNC_OFS_DEVSEL) begin
        devsel_q <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q       <= PNC_IDLE;
      stat_q        <= '{bsy: 1'b0, drdy: 1'b1, df_dmrd: 1'b0, serv: 1'b0, drq: 1'b0, rsvd: 2'b00, err_chk: 1'b0};
      error_q       <= PNC_RST_ERROR;
      count_q       <= PNC_RST_TF;
      bcount_q      <= PNC_RST_BCOUNT;
      in_packet_q   <= 1'b0;
      limit_q       <= PNC_RST_BCOUNT;
      remain_q      <= 24'h000000;
      left_q        <= 16'h0000;
      to_host_q     <= 1'b0;
      wcnt_q        <= '0;
      pkt_q         <= '0;
      queue_abort_o <= 1'b0;
      pkt_valid_o   <= 1'b0;
      rd_take_o     <= 1'b0;
      wr_valid_o    <= 1'b0;
      wr_data_o     <= 16'h0000;
    end else begin
      queue_abort_o <= 1'b0;
      pkt_valid_o   <= 1'b0;
      rd_take_o     <= 1'b0;
      wr_valid_o    <= 1'b0;
      case (state_q)
        PNC_IDLE: begin
          if (wr_fire && tf_open && wb_adr_i == PNC_OFS_COUNT) begin
            count_q <= wb_dat_i[7:0];
          end
          if (wr_fire && tf_open && wb_adr_i == PNC_OFS_BCLO) begin
            bcount_q[7:0] <= wb_dat_i[7:0];
          end
          if (wr_fire && tf_open && wb_adr_i == PNC_OFS_BCHI) begin
            bcount_q[15:8] <= wb_dat_i[7:0];
          end
          if (cmd_wr) begin
            if (wb_dat_i[7:0] == PNC_CMD_PACKET && PACKET_SUP) begin
              in_packet_q <= 1'b1;
              limit_q     <= bcount_q;
              count_q     <= {(QUEUE_SUP && OVL_SUP && feat_q[PNC_FEAT_OVL]) ? count_q[7:3] : 5'h00,
                              1'b0, 1'b0, 1'b1};
              stat_q      <= '{bsy: 1'b0, drdy: stat_q.drdy, df_dmrd: 1'b0, serv: 1'b0, drq: 1'b1,
                               rsvd: 2'b00, err_chk: 1'b0};
              wcnt_q      <= '0;
              state_q     <= PNC_PKT_WAIT;
            end else begin
              // nop, and every unsupported code, fails with abort
              if (wb_dat_i[7:0] == PNC_CMD_NOP && OVL_SUP && feat_q == PNC_NOP_FLUSH) begin
                queue_abort_o <= 1'b1;
              end
              error_q <= PNC_ERR_ABRT;
              stat_q  <= '{bsy: 1'b0, drdy: 1'b1, df_dmrd: dev_fault_i, serv: 1'b0, drq: 1'b0,
                           rsvd: 2'b00, err_chk: 1'b1};
            end
          end
        end
        PNC_PKT_WAIT: begin
          // errors are held back until the whole packet is in
          if (data_wr) begin
            pkt_q[16*wcnt_q +: 16] <= wb_dat_i[15:0];
            if (wcnt_q == WCNT_W'(PKT_WORDS - 1)) begin
              pkt_valid_o <= 1'b1;
              stat_q.bsy  <= 1'b1;
              stat_q.drq  <= 1'b0;
              state_q     <= PNC_EXEC;
            end else begin
              wcnt_q <= wcnt_q + 1'b1;
            end
          end
        end
        PNC_EXEC: begin
          if (cmd_done_i) begin
            count_q <= {count_q[7:3], 1'b0, 1'b1, 1'b1};
            error_q <= cmd_err_i ? {sense_i, 4'h0} : PNC_RST_ERROR;
            stat_q  <= '{bsy: 1'b0, drdy: 1'b1, df_dmrd: 1'b0, serv: 1'b0, drq: 1'b0,
                         rsvd: 2'b00, err_chk: cmd_err_i};
            state_q <= PNC_IDLE;
            in_packet_q <= 1'b0;
          end else if (xfer_start_i) begin
            to_host_q <= xfer_to_host_i;
            if (pkt_dma_o) begin
              count_q <= {count_q[7:3], 1'b0, xfer_to_host_i, 1'b0};
              stat_q  <= '{bsy: 1'b0, drdy: stat_q.drdy, df_dmrd: DMA_OVL_SUP, serv: 1'b0, drq: 1'b1,
                           rsvd: 2'b00, err_chk: 1'b0};
              state_q <= PNC_DMA;
            end else if (limit_q == 16'h0000 || first_chunk == 16'h0000) begin
              // zero limit, or an odd limit of one on a longer transfer
              count_q     <= {count_q[7:3], 1'b0, 1'b1, 1'b1};
              error_q     <= PNC_ERR_ABRT;
              stat_q      <= '{bsy: 1'b0, drdy: 1'b1, df_dmrd: dev_fault_i, serv: 1'b0, drq: 1'b0,
                               rsvd: 2'b00, err_chk: 1'b1};
              state_q     <= PNC_IDLE;
              in_packet_q <= 1'b0;
            end else begin
              remain_q <= xfer_len_i;
              left_q   <= first_chunk;
              bcount_q <= first_chunk;
              count_q  <= {count_q[7:3], 1'b0, xfer_to_host_i, 1'b0};
              stat_q   <= '{bsy: 1'b0, drdy: stat_q.drdy, df_dmrd: 1'b0, serv: 1'b0, drq: 1'b1,
                            rsvd: 2'b00, err_chk: 1'b0};
              state_q  <= PNC_PIO;
            end
          end
        end
        PNC_PIO: begin
          if ((to_host_q && data_rd) || (!to_host_q && data_wr)) begin
            rd_take_o  <= to_host_q;
            wr_valid_o <= !to_host_q;
            wr_data_o  <= wb_dat_i[15:0];
            // an odd final word carries one byte in the low lane
            if (left_q <= 16'h0002) begin
              remain_q   <= remain_q - {8'h00, bcount_q};
              left_q     <= 16'h0000;
              stat_q.bsy <= 1'b1;
              stat_q.drq <= 1'b0;
              state_q    <= (remain_q == {8'h00, bcount_q}) ? PNC_EXEC : PNC_NEXT;
            end else begin
              left_q <= left_q - 16'h0002;
            end
          end
        end
        PNC_NEXT: begin
          left_q     <= chunk_size(remain_q, limit_q);
          bcount_q   <= chunk_size(remain_q, limit_q);
          stat_q.bsy <= 1'b0;
          stat_q.drq <= 1'b1;
          state_q    <= PNC_PIO;
        end
        PNC_DMA: begin
          if (cmd_done_i) begin
            count_q     <= {count_q[7:3], 1'b0, 1'b1, 1'b1};
            error_q     <= cmd_err_i ? {sense_i, 4'h0} : PNC_RST_ERROR;
            stat_q      <= '{bsy: 1'b0, drdy: 1'b1, df_dmrd: 1'b0, serv: 1'b0, drq: 1'b0,
                             rsvd: 2'b00, err_chk: cmd_err_i};
            state_q     <= PNC_IDLE;
            in_packet_q <= 1'b0;
          end
        end
        default: begin
          state_q <= PNC_IDLE;
        end
      endcase
    end
  end

  // ******************************************************
  // packet-phase attributes handed to the back end
  // ******************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_ovl_o <= 1'b0;
      pkt_dma_o <= 1'b0;
      pkt_tag_o <= 5'h00;
    end else if (cmd_wr && wb_dat_i[7:0] == PNC_CMD_PACKET) begin
      pkt_ovl_o <= feat_q[PNC_FEAT_OVL] && OVL_SUP;
      pkt_dma_o <= feat_q[PNC_FEAT_DMA];
      pkt_tag_o <= QUEUE_SUP ? count_q[7:3] : 5'h00;
    end
  end

  assign pkt_data_o = pkt_q;
endmodule

//--- src/pnc_pkg.sv
// constants, types and register map of the packet and nop command handler
package pnc_pkg;
  // ******************************************************
  // register byte offsets on the wishbone slave
  // ******************************************************
  localparam logic [7:0] PNC_OFS_DATA   = 8'h00;
  localparam logic [7:0] PNC_OFS_FEAT   = 8'h04;
  localparam logic [7:0] PNC_OFS_COUNT  = 8'h08;
  localparam logic [7:0] PNC_OFS_SECNUM = 8'h0c;
  localparam logic [7:0] PNC_OFS_BCLO   = 8'h10;
  localparam logic [7:0] PNC_OFS_BCHI   = 8'h14;
  localparam logic [7:0] PNC_OFS_DEVSEL = 8'h18;
  localparam logic [7:0] PNC_OFS_CMD    = 8'h1c;

  // ******************************************************
  // command codes, subcommands and field positions
  // ******************************************************
  localparam logic [7:0]  PNC_CMD_NOP      = 8'h00;
  localparam logic [7:0]  PNC_CMD_PACKET   = 8'ha0;
  localparam logic [7:0]  PNC_NOP_FLUSH    = 8'h00;
  localparam int          PNC_FEAT_OVL     = 1;
  localparam int          PNC_FEAT_DMA     = 0;
  localparam logic [7:0]  PNC_ERR_ABRT     = 8'h04;
  localparam logic [15:0] PNC_BC_ALL_ONES  = 16'hffff;
  localparam logic [15:0] PNC_BC_MAX       = 16'hfffe;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [7:0]  PNC_RST_ERROR    = 8'h00;
  localparam logic [7:0]  PNC_RST_TF       = 8'h00;
  localparam logic [15:0] PNC_RST_BCOUNT   = 16'h0000;

  typedef struct packed {
    logic       bsy;
    logic       drdy;
    logic       df_dmrd;
    logic       serv;
    logic       drq;
    logic [1:0] rsvd;
    logic       err_chk;
  } pnc_status_t;

  typedef struct packed {
    logic [4:0] tag;
    logic       rel;
    logic       io;
    logic       cd;
  } pnc_reason_t;

  typedef enum logic [2:0] {
    PNC_IDLE,
    PNC_PKT_WAIT,
    PNC_EXEC,
    PNC_PIO,
    PNC_NEXT,
    PNC_DMA
  } pnc_state_t;
endpackage

//--- verification/pnc_handler_chk.sv
// port assertions for the nop and packet command handler
module pnc_handler_chk
  import pnc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        queue_abort_o,
  input wire logic        pkt_valid_o,
  input wire logic        pkt_ovl_o,
  input wire logic        pkt_dma_o,
  input wire logic        rd_take_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // shadows; valid only because the host writes while idle
  // ********
  logic [7:0] feat_q;
  logic       nop_q;
  logic       cmd0;
  logic       rd_dat;
  assign cmd0   = wb_ack_o && wb_we_i && wb_adr_i == PNC_OFS_CMD && wb_dat_i[7:0] == PNC_CMD_NOP;
  assign rd_dat = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == PNC_OFS_DATA;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feat_q <= 8'h00;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == PNC_OFS_FEAT) begin
      feat_q <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nop_q <= 1'b0;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == PNC_OFS_CMD) begin
      nop_q <= wb_dat_i[7:0] != PNC_CMD_PACKET;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack wider than one cycle");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due)
    else $error("ack late");
  property p_flush; cmd0 && feat_q == PNC_NOP_FLUSH |-> ##[1:2] queue_abort_o; endproperty
  a_flush: assert property (p_flush)
    else $error("queue not flushed");
  property p_keep; cmd0 && feat_q != PNC_NOP_FLUSH |=> !queue_abort_o [*3]; endproperty
  a_keep: assert property (p_keep)
    else $error("queue flushed by other subcommand");
  property p_nop_stat;
    wb_ack_o && !wb_we_i && wb_adr_i == PNC_OFS_CMD && nop_q |-> (wb_dat_o[7:0] & 8'hdf) == 8'h41;
  endproperty
  a_nop_stat: assert property (p_nop_stat)
    else $error("nop status wrong");
  property p_nop_err;
    wb_ack_o && !wb_we_i && wb_adr_i == PNC_OFS_FEAT && nop_q |-> wb_dat_o[7:0] == PNC_ERR_ABRT;
  endproperty
  a_nop_err: assert property (p_nop_err)
    else $error("nop error wrong");
  property p_mode; pkt_valid_o |-> {pkt_ovl_o, pkt_dma_o} == feat_q[1:0]; endproperty
  a_mode: assert property (p_mode)
    else $error("packet mode bits wrong");
  property p_take; rd_take_o |-> $past(rd_dat, 1) || $past(rd_dat, 2); endproperty
  a_take: assert property (p_take)
    else $error("word taken without read");
  c_flush: cover property (queue_abort_o);
  c_pkt: cover property (pkt_valid_o);
  c_take: cover property (rd_take_o);
endmodule

bind pnc_handler pnc_handler_chk u_pnc_handler_chk (.*);

//--- verification/pnc_host_model.sv
// host adapter model: wishbone master on the task-file registers
module pnc_host_model
  import pnc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o = 1'b0,
  output logic             stb_o = 1'b0,
  output logic             we_o = 1'b0,
  output logic [7:0]       adr_o = 8'hff,
  output logic [3:0]       sel_o = 4'h0,
  output logic [31:0]      dat_o = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // released address and data lines carry inverted values; we_o keeps the stale one
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'h3, 16'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i[15:0];
    {cyc_o, stb_o, adr_o, sel_o, dat_o} <= {2'b00, ~a, 4'h0, 16'hffff, ~d};
  endtask
  task automatic nop(input logic [7:0] sub);
    logic [15:0] q;
    acc(1'b0, PNC_OFS_CMD, 16'h0, q);
    if (q[6] === 1'b1) begin
      acc(1'b1, PNC_OFS_FEAT, {8'h0, sub}, q);
      acc(1'b1, PNC_OFS_CMD, {8'h0, PNC_CMD_NOP}, q);
    end
  endtask
  // all-ones limit left as is: the device folds it itself
  task automatic pkt(input logic [7:0] ft, input logic [4:0] tg, input logic [15:0] lim, input logic [23:0] len);
    logic [15:0] q;
    logic [15:0] l;
    l = (len > lim && lim[0] && lim != PNC_BC_ALL_ONES) ? lim - 16'h1 : lim;
    acc(1'b1, PNC_OFS_FEAT, {8'h0, ft}, q);
    acc(1'b1, PNC_OFS_COUNT, {8'h0, tg, 3'b000}, q);
    acc(1'b1, PNC_OFS_BCLO, {8'h0, l[7:0]}, q);
    acc(1'b1, PNC_OFS_BCHI, {8'h0, l[15:8]}, q);
    acc(1'b1, PNC_OFS_CMD, {8'h0, PNC_CMD_PACKET}, q);
  endtask
endmodule

//--- verification/tb.sv
// self-checking bench for the nop and packet command handler
module tb
  import pnc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, cyc, stb, we, ack, qa, pv, xs, xdir, done, derr, dflt, serv;
  logic [7:0]  adr;
  logic [3:0]  sel, sense;
  logic [31:0] wdat, rdat;
  logic [95:0] pdat;
  logic [23:0] xlen;
  logic [15:0] rdw;
  logic        wval;
  logic [15:0] wdo, wdq;
  logic [4:0]  ptag;
  int          n_mismatch, checks_done, n_qa, n_pv, n_wv;
  pnc_handler #(.PKT_BYTES(12)) u_pnc_handler (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .queue_abort_o(qa),
    .pkt_valid_o(pv), .pkt_data_o(pdat), .pkt_ovl_o(), .pkt_dma_o(), .pkt_tag_o(ptag),
    .xfer_start_i(xs), .xfer_len_i(xlen), .xfer_to_host_i(xdir), .rd_data_i(rdw), .rd_take_o(),
    .wr_data_o(wdo), .wr_valid_o(wval), .cmd_done_i(done), .cmd_err_i(derr), .sense_i(sense),
    .dev_fault_i(dflt), .serv_i(serv));
  pnc_host_model u_pnc_host_model (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (qa === 1'b1) n_qa++;
    if (pv === 1'b1) n_pv++;
    if (wval === 1'b1) n_wv++;
    if (wval === 1'b1) wdq <= wdo;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m, input string nm);
    logic [15:0] q;
    u_pnc_host_model.acc(1'b0, a, 16'h0, q);
    chk(nm, e, q & m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    u_pnc_host_model.acc(1'b1, a, d, q);
  endtask
  task automatic rdbc(input logic [15:0] e, input string nm);
    logic [15:0] lo, hi;
    u_pnc_host_model.acc(1'b0, PNC_OFS_BCLO, 16'h0, lo);
    u_pnc_host_model.acc(1'b0, PNC_OFS_BCHI, 16'h0, hi);
    chk(nm, e, {hi[7:0], lo[7:0]});
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic fin(input logic e, input logic [3:0] s);
    repeat (2) @(posedge clk);
    {done, derr, sense} <= {1'b1, e, s};
    @(posedge clk);
    {done, derr} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    rdc(PNC_OFS_CMD, 16'h0040, 16'h00ff, "status");
    rdc(PNC_OFS_FEAT, 16'h0000, 16'h00ff, "error");
    wr(8'h20, 16'h1234);
    rdc(8'h20, 16'h0000, 16'hffff, "unmapped");
  endtask
  task automatic t_nop(input logic [7:0] sub, input logic df);
    dflt <= df;
    wr(PNC_OFS_SECNUM, 16'h005a);
    wr(PNC_OFS_DEVSEL, 16'h00e1);
    wr(PNC_OFS_BCHI, 16'h0096);
    n_qa = 0;
    u_pnc_host_model.nop(sub);
    repeat (3) @(posedge clk);
    chk("queue_abort", {15'h0, sub == PNC_NOP_FLUSH}, n_qa[15:0]);
    rdc(PNC_OFS_CMD, {10'h001, df, 5'h01}, 16'h00ff, "nop_status");
    rdc(PNC_OFS_FEAT, {8'h0, PNC_ERR_ABRT}, 16'h00ff, "nop_error");
    rdc(PNC_OFS_SECNUM, 16'h005a, 16'h00ff, "secnum");
    rdc(PNC_OFS_DEVSEL, 16'h00e1, 16'h00ff, "devsel");
    rdc(PNC_OFS_BCHI, 16'h0096, 16'h00ff, "bc_high");
  endtask
  task automatic t_pkt(input logic [7:0] ft, input logic [4:0] tg, input logic [15:0] lim,
                       input logic [23:0] len, input logic dir);
    logic [23:0] rem;
    logic [15:0] ch, l, q, m;
    int k;
    {serv, xlen, xdir} <= {1'b1, len, dir};
    n_pv = 0;
    u_pnc_host_model.pkt(ft, tg, lim, len);
    rdc(PNC_OFS_COUNT, {8'h0, ft[1] ? tg : 5'h0, 3'b001}, 16'h00ff, "wait_reason");
    rdc(PNC_OFS_CMD, 16'h0018, 16'h00b9, "wait_status");
    l = (len > {8'h0, lim} && lim[0] && lim != PNC_BC_ALL_ONES) ? lim - 16'h1 : lim;
    rdbc(l, "wait_bc");
    for (k = 0; k < 6; k++) wr(PNC_OFS_DATA, 16'h1100 + k[15:0]);
    repeat (2) @(posedge clk);
    chk("pkt_valid", 16'h0001, n_pv[15:0]);
    chk("pkt_byte0", 16'h1100, pdat[15:0]);
    chk("pkt_tag", {11'h0, tg}, {11'h0, ptag});
    n_wv = 0;
    @(posedge clk);
    xs <= 1'b1;
    @(posedge clk);
    xs <= 1'b0;
    repeat (2) @(posedge clk);
    if (lim == 16'h0) begin
      rdc(PNC_OFS_FEAT, {8'h0, PNC_ERR_ABRT}, 16'h00ff, "zero_lim_error");
      rdc(PNC_OFS_CMD, 16'h0041, 16'h00c9, "zero_lim_status");
      return;
    end
    if (ft[0]) begin
      rdc(PNC_OFS_CMD, 16'h0028, 16'h00a9, "dma_status");
      fin(1'b1, 4'h5);
      rdc(PNC_OFS_FEAT, 16'h0050, 16'h00f0, "sense");
      rdc(PNC_OFS_CMD, 16'h0041, 16'h00c9, "err_status");
      return;
    end
    l = (l == PNC_BC_ALL_ONES) ? PNC_BC_MAX : l;
    rem = len;
    while (rem != 24'h0) begin
      do begin
        u_pnc_host_model.acc(1'b0, PNC_OFS_CMD, 16'h0, q);
      end while (!(q[3] === 1'b1 && q[7] === 1'b0));
      ch = (rem > {8'h0, l}) ? (l & 16'hfffe) : rem[15:0];
      rdbc(ch, "chunk_bc");
      rdc(PNC_OFS_COUNT, {14'h0, dir, 1'b0}, 16'h0007, "data_reason");
      rdc(PNC_OFS_CMD, 16'h0008, 16'h0089, "data_status");
      if (ch == PNC_BC_MAX) begin
        do_reset();
        rdc(PNC_OFS_CMD, 16'h0040, 16'h00ff, "reset_status");
        return;
      end
      for (k = 0; k < (ch + 1) / 2; k++) begin
        m = (2 * k + 1 == ch) ? 16'h00ff : 16'hffff;
        if (dir) rdc(PNC_OFS_DATA, rdw & m, m, "data_word");
        else wr(PNC_OFS_DATA, 16'h2200 + k[15:0]);
      end
      rem = rem - {8'h0, ch};
    end
    fin(1'b0, 4'h0);
    if (!dir) chk("host_words", (len[15:0] + 16'h1) >> 1, n_wv[15:0]);
    if (!dir) chk("last_word", 16'h2200 + ((ch + 16'h1) >> 1) - 16'h1, wdq);
    rdc(PNC_OFS_CMD, 16'h0040, 16'h00c9, "done_status");
    rdc(PNC_OFS_COUNT, 16'h0003, 16'h0007, "done_reason");
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {rst, xs, xdir, done, derr, dflt, serv, sense, xlen} = {1'b1, 10'h0, 24'h0};
    rdw = 16'hc3a5;
    do_reset();
    t_reset();
    t_nop(8'h00, 1'b0);
    t_nop(8'h01, 1'b1);
    t_nop(8'hff, 1'b0);
    t_pkt(8'h02, 5'h13, 16'h0006, 24'h00000f, 1'b1);
    t_pkt(8'h00, 5'h0a, 16'h0101, 24'h000004, 1'b0);
    t_pkt(8'h00, 5'h00, 16'h0000, 24'h000004, 1'b0);
    t_pkt(8'h03, 5'h05, 16'h0100, 24'h000040, 1'b1);
    t_pkt(8'h00, 5'h00, 16'h0003, 24'h000004, 1'b0);
    t_pkt(8'h00, 5'h00, 16'hffff, 24'h020000, 1'b1);
    final_report();
  end
  // generous bound: the whole sequence needs well under a thousand of the 20000 cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    final_report();
  end
endmodule
